// *** test/qbs_ctrl_model.sv ***
// Purpose: memory controller model for the burst sram port
// Assumes: the first edge after reset is a read slot
// Notes: records each read word with its half-cycle index
`timescale 1ns/100ps
`default_nettype none
module qbs_ctrl_model (
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    // request side
    output logic [3:0] addr_o,
    output logic rd_sel_n_o,
    output logic wr_sel_n_o,
    output logic [35:0] wd_rise_o,
    output logic [35:0] wd_fall_o,
    output logic [3:0] be_rise_n_o,
    output logic [3:0] be_fall_n_o,
    // read return
    input wire logic [35:0] rd_rise_i,
    input wire logic [35:0] rd_fall_i,
    input wire logic [1:0] valid_i,
    input wire logic echo_p_i,
    input wire logic echo_n_i
);
    logic rd_next_q;
    logic echo_q;
    int edge_n;
    int bad = 0;
    bit wr_busy = 0;
    logic [35:0] rx_w[$];
    int rx_h[$];
    int rd_n[$];
    initial begin
        addr_o = 4'h0;
        rd_sel_n_o = 1'b1;
        wr_sel_n_o = 1'b1;
        wd_rise_o = 36'h0;
        wd_fall_o = 36'h0;
        be_rise_n_o = 4'hF;
        be_fall_n_o = 4'hF;
    end
    // slot phase tracked like the device, so requests land in the right slot
    always @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_next_q <= 1'b1;
            edge_n <= 0;
        end else begin
            rd_next_q <= ~rd_next_q;
            edge_n <= edge_n + 1;
        end
    end
    // sampled mid-cycle so registered outputs have settled
    always @(negedge clock_i) begin
        if (reset_n_i && edge_n > 0) begin
            if (echo_p_i !== ~echo_n_i || echo_p_i === echo_q) bad++;
            if (valid_i[0] === 1'b1) begin
                rx_w.push_back(rd_rise_i);
                rx_h.push_back(2 * edge_n);
            end else if (rd_rise_i !== 36'h0) bad++;
            if (valid_i[1] === 1'b1) begin
                rx_w.push_back(rd_fall_i);
                rx_h.push_back(2 * edge_n + 1);
            end else if (rd_fall_i !== 36'h0) bad++;
        end
        echo_q = echo_p_i;
    end
    task automatic rd(input logic [3:0] a);
        do @(negedge clock_i); while (rd_next_q !== 1'b0);
        rd_n.push_back(edge_n + 2);
        @(posedge clock_i);
        addr_o <= a;
        rd_sel_n_o <= 1'b0;
        @(posedge clock_i);
        rd_sel_n_o <= 1'b1;
    endtask
    // no write strobe timing is supplied: the device times the array write
    task automatic wr(input logic [3:0] a, input logic [143:0] w, input logic [15:0] m);
        do @(negedge clock_i); while (rd_next_q !== 1'b1);
        @(posedge clock_i);
        wr_busy = 1;
        addr_o <= a;
        wr_sel_n_o <= 1'b0;
        wd_rise_o <= w[35:0];
        wd_fall_o <= w[71:36];
        be_rise_n_o <= m[3:0];
        be_fall_n_o <= m[7:4];
        @(posedge clock_i);
        wr_sel_n_o <= 1'b1;
        wd_rise_o <= w[107:72];
        wd_fall_o <= w[143:108];
        be_rise_n_o <= m[11:8];
        be_fall_n_o <= m[15:12];
        @(posedge clock_i);
        // stale data must not look like the last word
        wd_rise_o <= ~w[107:72];
        wd_fall_o <= ~w[143:108];
        wr_busy = 0;
    endtask
    // selects asserted in the wrong slots on purpose
    task automatic stray(input logic [3:0] a);
        do @(negedge clock_i); while (rd_next_q !== 1'b0);
        @(posedge clock_i);
        addr_o <= a;
        wr_sel_n_o <= 1'b0;
        wd_rise_o <= 36'hFFFFFFFFF;
        wd_fall_o <= 36'hFFFFFFFFF;
        be_rise_n_o <= 4'h0;
        be_fall_n_o <= 4'h0;
        @(posedge clock_i);
        wr_sel_n_o <= 1'b1;
        rd_sel_n_o <= 1'b0;
        @(posedge clock_i);
        rd_sel_n_o <= 1'b1;
    endtask
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
// Purpose: self-checking bench for the burst sram port
// Assumes: 4-bit burst address, 36-bit words
// Notes: expected words come from a lane-merged reference copy
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic clock_i;
    logic reset_n_i = 1'b0;
    logic lat = 1'b0;
    logic [3:0] addr;
    logic rd_sel_n, wr_sel_n, echo_p, echo_n;
    logic [35:0] wd_r, wd_f, rd_r, rd_f;
    logic [3:0] be_r_n, be_f_n;
    logic [1:0] vld;
    logic [143:0] mem[16];
    logic [143:0] exp_q[$];
    int mismatches = 0;
    int checked = 0;
    int cycles = 0;
    qbs_port #(.ADDR_W(4)) u_qbs_port (.clock_i(clock_i), .reset_n_i(reset_n_i), .addr_i(addr),
        .rd_sel_n_i(rd_sel_n), .wr_sel_n_i(wr_sel_n), .latency_select_pin_i(lat), .wr_data_rise_i(wd_r),
        .wr_data_fall_i(wd_f), .byte_write_selects_rise_n_i(be_r_n), .byte_write_selects_fall_n_i(be_f_n),
        .rd_data_rise_o(rd_r), .rd_data_fall_o(rd_f), .read_valid_flag_o(vld),
        .echo_clock_pair_p_o(echo_p), .echo_clock_pair_n_o(echo_n));
    qbs_ctrl_model u_qbs_ctrl_model (.clock_i(clock_i), .reset_n_i(reset_n_i), .addr_o(addr),
        .rd_sel_n_o(rd_sel_n), .wr_sel_n_o(wr_sel_n), .wd_rise_o(wd_r), .wd_fall_o(wd_f),
        .be_rise_n_o(be_r_n), .be_fall_n_o(be_f_n), .rd_rise_i(rd_r), .rd_fall_i(rd_f),
        .valid_i(vld), .echo_p_i(echo_p), .echo_n_i(echo_n));
    initial begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end
    task automatic finish_test();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            finish_test();
        end
    end
    task automatic cmp_w(input string what, input logic [35:0] e, input logic [35:0] g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic cmp_i(input string what, input int e, input int g);
        checked++;
        if (g != e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %0d seen %0d", what, e, g);
        end
    endtask
    function automatic logic [143:0] pat(input logic [7:0] s);
        return {{28'h0000003, s}, {28'h0000002, s}, {28'h0000001, s}, {28'h0000000, s}};
    endfunction
    // masked lanes keep their old contents
    function automatic logic [143:0] mrg(input logic [143:0] o, input logic [143:0] w, input logic [15:0] m);
        for (int i = 0; i < 16; i++)
            if (!m[i]) o[9*i+:9] = w[9*i+:9];
        return o;
    endfunction
    task automatic do_wr(input logic [3:0] a, input logic [143:0] w, input logic [15:0] m);
        mem[a] = mrg(mem[a], w, m);
        u_qbs_ctrl_model.wr(a, w, m);
    endtask
    task automatic do_rd(input logic [3:0] a);
        exp_q.push_back(mem[a]);
        u_qbs_ctrl_model.rd(a);
    endtask
    task automatic check_reads(input string name);
        int n;
        repeat (8) @(negedge clock_i);
        n = u_qbs_ctrl_model.rd_n.size();
        cmp_i("read word count", 4 * n, u_qbs_ctrl_model.rx_w.size());
        if (u_qbs_ctrl_model.rx_w.size() == 4 * n)
            for (int i = 0; i < n; i++)
                for (int k = 0; k < 4; k++) begin
                    cmp_w("read word", exp_q[i][36*k+:36], u_qbs_ctrl_model.rx_w[4*i+k]);
                    cmp_i("word half-cycle", 2 * u_qbs_ctrl_model.rd_n[i] + (lat ? 5 : 2) + k,
                        u_qbs_ctrl_model.rx_h[4*i+k]);
                end
        u_qbs_ctrl_model.rd_n.delete();
        u_qbs_ctrl_model.rx_w.delete();
        u_qbs_ctrl_model.rx_h.delete();
        exp_q.delete();
        $display("test %s done", name);
    endtask
    initial begin
        repeat (3) @(posedge clock_i);
        cmp_w("valid in reset", 36'h0, {34'h0, vld});
        cmp_w("echo in reset", 36'h1, {34'h0, echo_p, echo_n});
        reset_n_i <= 1'b1;
        do_wr(4'h2, pat(8'h11), 16'h0000);
        do_wr(4'h5, pat(8'h22), 16'h0000);
        do_rd(4'h2);
        do_rd(4'h5);
        check_reads("basic");
        do_wr(4'h2, pat(8'h33), 16'hA5C3);
        do_rd(4'h2);
        check_reads("byte lanes");
        // read issued while the write burst is still arriving
        fork
            do_wr(4'h7, pat(8'h44), 16'h0000);
            begin
                wait (u_qbs_ctrl_model.wr_busy);
                do_rd(4'h7);
            end
        join
        check_reads("concurrent");
        @(posedge clock_i);
        lat <= 1'b1;
        repeat (4) @(posedge clock_i);
        do_rd(4'h2);
        do_rd(4'h5);
        check_reads("long latency");
        u_qbs_ctrl_model.stray(4'h5);
        check_reads("wrong slots");
        do_rd(4'h5);
        check_reads("wrong slots readback");
        cmp_i("echo and idle errors", 0, u_qbs_ctrl_model.bad);
        finish_test();
    end
endmodule
`default_nettype wire

// *** verilog/qbs_burst_array.sv ***
// Purpose: flip-flop storage, four words per burst address, byte-lane writes
// Assumes: write strobe arrives once all four words are known
// Notes: no reset on storage; contents are undefined until written
`timescale 1ns/100ps
`default_nettype none
`include "qbs_map.svh"
module qbs_burst_array #(
    parameter int ADDR_W = `QBS_ADDR_W,
    parameter int DATA_W = `QBS_DATA_W,
    parameter int LANES = DATA_W / `QBS_LANE_W
) (
    // clock
    input wire logic clock_i,
    // write side
    input wire logic we_i,
    input wire logic [ADDR_W-1:0] waddr_i,
    input wire logic [4*DATA_W-1:0] wdata_i,
    input wire logic [4*LANES-1:0] wbe_n_i,
    // read side
    input wire logic [ADDR_W-1:0] raddr_i,
    output logic [4*DATA_W-1:0] rdata_o
);
    localparam int LW = `QBS_LANE_W;
    logic [DATA_W-1:0] mem [0:(1<<(ADDR_W+2))-1];

    // whole burst commits in one edge, with no pulse from outside
    always_ff @(posedge clock_i) begin
        for (int w = 0; w < `QBS_BURST_LEN; w++) begin
            for (int l = 0; l < LANES; l++) begin
                if (we_i && !wbe_n_i[w*LANES+l]) begin
                    mem[{waddr_i, w[1:0]}][l*LW +: LW] <= wdata_i[w*DATA_W+l*LW +: LW];
                end
            end
        end
    end

    for (genvar w = 0; w < `QBS_BURST_LEN; w++) begin : g_rd
        assign rdata_o[w*DATA_W +: DATA_W] = mem[{raddr_i, 2'(w)}];
    end
endmodule
`default_nettype wire

// *** verilog/qbs_map.svh ***
// Purpose: offsets, widths and timing counts for the burst sram port
// Assumes: one clock at 25 MHz; each cycle carries a rise word and a fall word
// Notes: definitions only
`ifndef QBS_MAP_SVH
`define QBS_MAP_SVH

`define QBS_DATA_W 36
`define QBS_ADDR_W 17
`define QBS_LANE_W 9
`define QBS_BURST_LEN 4
`define QBS_QUEUE_HALVES 8
`define QBS_START_LONG 3
`define QBS_START_SHORT 0
`define QBS_IDLE_CLEAR 5

`endif

// *** verilog/qbs_pkg.sv ***
// Purpose: shared types of the burst sram port
// Assumes: nothing
// Notes: types only; numbers live in qbs_map.svh
`default_nettype none
package qbs_pkg;
    typedef enum logic {QBS_SLOT_WRITE, QBS_SLOT_READ} qbs_slot_t;
    typedef enum logic {QBS_WR_IDLE, QBS_WR_HALF} qbs_wr_state_t;
endpackage
`default_nettype wire

// *** verilog/qbs_port.sv ***
// Purpose: interface logic of a four-word burst sram with split ddr ports
// Assumes: pins are synchronous to clock_i; latency select is static
// Notes: each cycle models both clock phases as a rise word and a fall word
`timescale 1ns/100ps
`default_nettype none
`include "qbs_map.svh"
module qbs_port #(
    parameter int ADDR_W = `QBS_ADDR_W,
    parameter int DATA_W = `QBS_DATA_W,
    parameter int LANES = DATA_W / `QBS_LANE_W
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    // shared address, port selects, latency select
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic rd_sel_n_i,
    input wire logic wr_sel_n_i,
    input wire logic latency_select_pin_i,
    // write port
    input wire logic [DATA_W-1:0] wr_data_rise_i,
    input wire logic [DATA_W-1:0] wr_data_fall_i,
    input wire logic [LANES-1:0] byte_write_selects_rise_n_i,
    input wire logic [LANES-1:0] byte_write_selects_fall_n_i,
    // read port
    output logic [DATA_W-1:0] rd_data_rise_o,
    output logic [DATA_W-1:0] rd_data_fall_o,
    output logic [1:0] read_valid_flag_o,
    output logic echo_clock_pair_p_o,
    output logic echo_clock_pair_n_o
);
    localparam int LW = `QBS_LANE_W;
    localparam int QH = `QBS_QUEUE_HALVES;

    // input registers
    logic [ADDR_W-1:0] addr_q;
    logic rsel_n_q, wsel_n_q, lat_q;
    logic [DATA_W-1:0] wd_r_q, wd_f_q;
    logic [LANES-1:0] bw_r_q, bw_f_q;
    qbs_pkg::qbs_slot_t slot_q, slot_d;
    logic rd_go, wr_go;

    // every pin goes through a register before any logic sees it
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            addr_q <= '0;
            rsel_n_q <= 1'b1;
            wsel_n_q <= 1'b1;
            lat_q <= 1'b0;
            wd_r_q <= '0;
            wd_f_q <= '0;
            bw_r_q <= '1;
            bw_f_q <= '1;
            slot_q <= qbs_pkg::QBS_SLOT_WRITE;
        end else begin
            addr_q <= addr_i;
            rsel_n_q <= rd_sel_n_i;
            wsel_n_q <= wr_sel_n_i;
            lat_q <= latency_select_pin_i;
            wd_r_q <= wr_data_rise_i;
            wd_f_q <= wr_data_fall_i;
            bw_r_q <= byte_write_selects_rise_n_i;
            bw_f_q <= byte_write_selects_fall_n_i;
            slot_q <= slot_d;
        end
    end

    // slot strictly alternates; first edge after release is a read slot
    always_comb begin
        slot_d = (slot_q == qbs_pkg::QBS_SLOT_READ) ? qbs_pkg::QBS_SLOT_WRITE : qbs_pkg::QBS_SLOT_READ;
    end
    assign rd_go = (slot_q == qbs_pkg::QBS_SLOT_READ) && !rsel_n_q;
    assign wr_go = (slot_q == qbs_pkg::QBS_SLOT_WRITE) && !wsel_n_q;

    // write buffer: first two words wait for the second pair
    qbs_pkg::qbs_wr_state_t wr_st_q, wr_st_d;
    logic [ADDR_W-1:0] wb_addr_q, wb_addr_d;
    logic [DATA_W-1:0] wb_w0_q, wb_w0_d, wb_w1_q, wb_w1_d;
    logic [LANES-1:0] wb_be0_q, wb_be0_d, wb_be1_q, wb_be1_d;

    always_comb begin
        wb_addr_d = wb_addr_q;
        wb_w0_d = wb_w0_q;
        wb_w1_d = wb_w1_q;
        wb_be0_d = wb_be0_q;
        wb_be1_d = wb_be1_q;
        wr_st_d = qbs_pkg::QBS_WR_IDLE;
        unique case (wr_st_q)
            qbs_pkg::QBS_WR_IDLE,
            qbs_pkg::QBS_WR_HALF: begin
                if (wr_go) begin
                    wr_st_d = qbs_pkg::QBS_WR_HALF;
                    wb_addr_d = addr_q;
                    wb_w0_d = wd_r_q;
                    wb_w1_d = wd_f_q;
                    wb_be0_d = bw_r_q;
                    wb_be1_d = bw_f_q;
                end
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_st_q <= qbs_pkg::QBS_WR_IDLE;
            wb_addr_q <= '0;
            wb_w0_q <= '0;
            wb_w1_q <= '0;
            wb_be0_q <= '1;
            wb_be1_q <= '1;
        end else begin
            wr_st_q <= wr_st_d;
            wb_addr_q <= wb_addr_d;
            wb_w0_q <= wb_w0_d;
            wb_w1_q <= wb_w1_d;
            wb_be0_q <= wb_be0_d;
            wb_be1_q <= wb_be1_d;
        end
    end

    // array, written when the last word pair sits in the input registers
    logic arr_we;
    logic [4*DATA_W-1:0] arr_wdata, arr_rdata, fwd_words;
    logic [4*LANES-1:0] arr_wbe_n;
    logic fwd_hit;

    assign arr_we = (wr_st_q == qbs_pkg::QBS_WR_HALF);
    assign arr_wdata = {wd_f_q, wd_r_q, wb_w1_q, wb_w0_q};
    assign arr_wbe_n = {bw_f_q, bw_r_q, wb_be1_q, wb_be0_q};

    qbs_burst_array #(
        .ADDR_W(ADDR_W),
        .DATA_W(DATA_W),
        .LANES(LANES)
    ) u_array (
        .clock_i(clock_i),
        .we_i(arr_we),
        .waddr_i(wb_addr_q),
        .wdata_i(arr_wdata),
        .wbe_n_i(arr_wbe_n),
        .raddr_i(addr_q),
        .rdata_o(arr_rdata)
    );

    // a read landing on the burst being committed takes its selected lanes
    assign fwd_hit = arr_we && (wb_addr_q == addr_q);
    for (genvar g = 0; g < 4 * LANES; g++) begin : g_fwd
        assign fwd_words[g*LW +: LW] = (fwd_hit && !arr_wbe_n[g]) ? arr_wdata[g*LW +: LW]
                                                                  : arr_rdata[g*LW +: LW];
    end

    // half-slot queue: index 0 is the rise word of the next edge
    logic [QH-1:0] q_val_q, q_val_d, m_val;
    logic [DATA_W-1:0] q_dat_q [QH];
    logic [DATA_W-1:0] q_dat_d [QH];
    logic [DATA_W-1:0] m_dat [QH];
    logic [DATA_W-1:0] rise_q, rise_d, fall_q, fall_d;
    logic [1:0] vld_q, vld_d;
    logic echo_p_q, echo_n_q;

    always_comb begin
        int k;
        int start;
        k = 0;
        start = lat_q ? `QBS_START_LONG : `QBS_START_SHORT;
        for (int i = 0; i < QH; i++) begin
            k = i - start;
            if (rd_go && k >= 0 && k < `QBS_BURST_LEN) begin
                m_val[i] = 1'b1;
                m_dat[i] = fwd_words[k*DATA_W +: DATA_W];
            end else begin
                m_val[i] = q_val_q[i];
                m_dat[i] = q_dat_q[i];
            end
        end
        for (int i = 0; i < QH; i++) begin
            q_val_d[i] = (i < QH - 2) ? m_val[(i+2)%QH] : 1'b0;
            q_dat_d[i] = (i < QH - 2) ? m_dat[(i+2)%QH] : '0;
        end
        rise_d = m_val[0] ? m_dat[0] : '0;
        fall_d = m_val[1] ? m_dat[1] : '0;
        vld_d = m_val[1:0];
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            q_val_q <= '0;
            for (int i = 0; i < QH; i++) begin
                q_dat_q[i] <= '0;
            end
            rise_q <= '0;
            fall_q <= '0;
            vld_q <= 2'h0;
            echo_p_q <= 1'b0;
            echo_n_q <= 1'b1;
        end else begin
            q_val_q <= q_val_d;
            q_dat_q <= q_dat_d;
            rise_q <= rise_d;
            fall_q <= fall_d;
            vld_q <= vld_d;
            echo_p_q <= ~echo_p_q;
            echo_n_q <= ~echo_n_q;
        end
    end

    // outputs share the edge of the data so the echo pair stays aligned
    assign rd_data_rise_o = rise_q;
    assign rd_data_fall_o = fall_q;
    assign read_valid_flag_o = vld_q;
    assign echo_clock_pair_p_o = echo_p_q;
    assign echo_clock_pair_n_o = echo_n_q;

    // checking helpers
    logic [2:0] idle_cnt_q;
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            idle_cnt_q <= 3'h7;
        end else if (rd_go) begin
            idle_cnt_q <= 3'h0;
        end else if (idle_cnt_q != 3'h7) begin
            idle_cnt_q <= idle_cnt_q + 3'h1;
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);

    sequence long_burst_s;
        ##2 read_valid_flag_o[1] ##1 (read_valid_flag_o == 2'h3) ##1 read_valid_flag_o[0];
    endsequence
    sequence short_burst_s;
        ##1 (read_valid_flag_o == 2'h3) [*2];
    endsequence

    // the edge that releases reset still samples reset values, so skip it
    slot_alternates_a: assert property ($past(reset_n_i) |-> slot_q != $past(slot_q))
        else $error("address slot did not alternate");
    // read select in a write slot must start nothing; a proper read one slot later shows later
    read_slot_only_a: assert property (
        !rsel_n_q && slot_q == qbs_pkg::QBS_SLOT_WRITE && idle_cnt_q == 3'h7
        |=> read_valid_flag_o == 2'h0 ##1 (!lat_q || read_valid_flag_o == 2'h0))
        else $error("read started outside read slot");
    long_latency_a: assert property (rd_go && lat_q |-> long_burst_s)
        else $error("long latency burst misplaced");
    short_latency_a: assert property (rd_go && !lat_q |-> short_burst_s)
        else $error("short latency burst misplaced");
    valid_idle_a: assert property (idle_cnt_q >= 3'(`QBS_IDLE_CLEAR) |-> read_valid_flag_o == 2'h0)
        else $error("valid flag set with no burst");
    write_commit_a: assert property (wr_go |=> arr_we ##1 !arr_we)
        else $error("write not committed once");
    concurrent_write_a: assert property (wr_go && $past(rd_go) |=> arr_we)
        else $error("write held off by read");
    echo_pair_a: assert property (echo_clock_pair_p_o != echo_clock_pair_n_o
                                  && (!$past(reset_n_i) || echo_clock_pair_p_o != $past(echo_clock_pair_p_o)))
        else $error("echo pair not complementary");
    coherent_read_a: assert property (rd_go && !lat_q && lat_q == $past(lat_q, 2)
                                      |=> rd_data_rise_o == $past(fwd_words[DATA_W-1:0]))
        else $error("read word0 not newest data");
    word_order_a: assert property (rd_go && !lat_q && lat_q == $past(lat_q, 2)
                                   |-> ##2 rd_data_fall_o == $past(fwd_words[4*DATA_W-1:3*DATA_W], 2))
        else $error("burst word3 out of order");
endmodule
`default_nettype wire
